// ### logic/drpm_bank.sv
`timescale 1ns/10ps
`default_nettype none

module drpm_bank
    import drpm_pkg::*;
(
    input  wire logic        clk,             // 10 MHz system clock
    input  wire logic        nrst,            // Async reset, active low
    input  wire drpm_req_t   req,             // Parameter channel request
    output drpm_rsp_t        rsp,             // Parameter channel answer
    input  wire logic [15:0] dc_bus_voltage,  // Bus voltage, 100 mV per count
    input  wire logic [15:0] uv_off_level,    // Switch-off threshold from power stage
    input  wire logic [15:0] uv_stop_level,   // Quick Stop threshold from power stage
    input  wire logic [15:0] boot_station,    // Station number read from NV at power-up
    input  wire logic [15:0] boot_react,      // Fault reaction read from NV at power-up
    output drpm_nv_t         nv_wr,           // Word to nonvolatile memory
    input  wire logic        nv_wr_ready,     // NV memory accepts the word
    output logic             drive_disable,   // Power stage must switch off
    output logic             quick_stop,      // Quick Stop requested
    output logic [15:0]      active_station,  // Station number in use on the bus
    output logic             react_class1     // Channel fault raises error class 1
);

    drpm_nv_state_t state;
    logic           booted;
    logic           from_factory;
    logic [3:0]     nv_idx;
    logic [15:0]    station;
    logic [15:0]    react;
    logic           acc_wr;
    logic           acc_rd;
    logic           hit;
    logic           busy;
    logic           store_go;
    logic           restore_go;
    logic           user_go;
    logic           station_ok;
    logic           react_ok;
    logic [15:0]    next_rdata;
    logic [15:0]    item_value;

    // Range checks, used by boot capture and writes alike
    function automatic logic station_valid(input logic [15:0] v);
        return (v >= STATION_MIN) && (v <= STATION_MAX);
    endfunction

    function automatic logic react_valid(input logic [15:0] v);
        return (v == REACT_MODE_ERROR) || (v == REACT_CLASS1);
    endfunction

    assign acc_wr     = req.valid && req.write;
    assign acc_rd     = req.valid && !req.write;
    assign busy       = (state == NV_WRITE);
    assign station_ok = station_valid(req.wdata);
    assign react_ok   = react_valid(req.wdata);

    // Commands; a new NV operation while one runs is refused
    assign store_go   = acc_wr && (req.addr == ADDR_NV_STORE) && req.wdata[CMD_BIT]
                        && !busy;
    assign restore_go = acc_wr && (req.addr == ADDR_RESTORE)
                        && (req.wdata == RESTORE_FACTORY) && !busy;
    assign user_go    = acc_wr && (req.addr == ADDR_USER_DEFAULTS) && req.wdata[CMD_BIT];

    // Address decode
    always_comb begin
        hit = 1'b1;
        unique case (req.addr)
            ADDR_NV_STORE, ADDR_USER_DEFAULTS, ADDR_UV_OFF, ADDR_UV_STOP,
            ADDR_FAULT_REACT, ADDR_RESTORE, ADDR_STATION: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    // Read data; commands read nonzero only while their operation runs
    always_comb begin
        next_rdata = 16'h0000;
        unique case (req.addr)
            ADDR_NV_STORE:    next_rdata = (busy && !from_factory) ? CMD_BUSY_VALUE
                                                                   : 16'h0000;
            ADDR_RESTORE:     next_rdata = (busy && from_factory) ? CMD_BUSY_VALUE
                                                                  : 16'h0000;
            ADDR_USER_DEFAULTS: next_rdata = 16'h0000;
            ADDR_UV_OFF:      next_rdata = uv_off_level;
            ADDR_UV_STOP:     next_rdata = uv_stop_level;
            ADDR_FAULT_REACT: next_rdata = react;
            ADDR_STATION:     next_rdata = station;
            default:          next_rdata = 16'h0000;
        endcase
    end

    // Answer one cycle after each request; err marks unmapped or refused
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rsp <= '0;
        end else begin
            rsp.valid <= req.valid;
            rsp.rdata <= acc_rd ? next_rdata : 16'h0000;
            rsp.err   <= req.valid && (!hit
                         || (req.write && (req.addr == ADDR_UV_OFF
                                        || req.addr == ADDR_UV_STOP))
                         || (req.write && req.addr == ADDR_STATION && !station_ok)
                         || (req.write && req.addr == ADDR_FAULT_REACT && !react_ok)
                         || (req.write && req.addr == ADDR_RESTORE
                             && req.wdata != RESTORE_NONE
                             && req.wdata != RESTORE_FACTORY)
                         || ((req.write && req.addr == ADDR_NV_STORE && req.wdata[CMD_BIT]
                              || req.write && req.addr == ADDR_RESTORE
                                 && req.wdata == RESTORE_FACTORY) && busy));
        end
    end

    // Power-up copy; the boot values are caught on the first edge after release
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            booted <= 1'b0;
        end else begin
            booted <= 1'b1;
        end
    end

    // Station number in use, fixed from power-up to power-up
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            active_station <= FACTORY_STATION;
        end else if (!booted) begin
            active_station <= station_valid(boot_station) ? boot_station
                                                          : FACTORY_STATION;
        end
    end

    // Working station number; communication setting survives a user reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            station <= FACTORY_STATION;
        end else if (!booted) begin
            station <= station_valid(boot_station) ? boot_station : FACTORY_STATION;
        end else if (acc_wr && req.addr == ADDR_STATION && station_ok) begin
            station <= req.wdata;
        end
    end

    // Working fault reaction; a user reset returns it to its default
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            react <= FACTORY_REACT;
        end else if (!booted) begin
            react <= react_valid(boot_react) ? boot_react : FACTORY_REACT;
        end else if (user_go) begin
            react <= FACTORY_REACT;
        end else if (acc_wr && req.addr == ADDR_FAULT_REACT && react_ok) begin
            react <= req.wdata;
        end
    end

    // Fault reaction acts at once, unlike the station number
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            react_class1 <= 1'b0;
        end else begin
            react_class1 <= (react == REACT_CLASS1);
        end
    end

    // Undervoltage supervision; inclusive compare so reaching a level trips it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            drive_disable <= 1'b1;
            quick_stop    <= 1'b0;
        end else begin
            drive_disable <= (dc_bus_voltage <= uv_off_level);
            quick_stop    <= (dc_bus_voltage <= uv_stop_level);
        end
    end

    // Item offered to NV: live working copy for a save, factory value for a restore.
    // Restore never touches the working copies, so operation is unchanged till power-up.
    always_comb begin
        item_value = 16'h0000;
        unique case (nv_idx)
            NV_IDX_STATION: item_value = from_factory ? FACTORY_STATION : station;
            NV_IDX_REACT:   item_value = from_factory ? FACTORY_REACT : react;
            default:        item_value = 16'h0000;
        endcase
    end

    // NV write sequencer; user reset never starts it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state        <= NV_IDLE;
            nv_idx       <= 4'h0;
            from_factory <= 1'b0;
        end else begin
            unique case (state)
                NV_IDLE: begin
                    if (store_go || restore_go) begin
                        state        <= NV_WRITE;
                        nv_idx       <= NV_IDX_STATION;
                        from_factory <= restore_go;
                    end
                end
                NV_WRITE: begin
                    if (nv_wr_ready) begin
                        if (nv_idx == NV_IDX_LAST) begin
                            state <= NV_IDLE;
                        end else begin
                            nv_idx <= nv_idx + 4'h1;
                        end
                    end
                end
            endcase
        end
    end

    // Word toward NV memory held until accepted; one driver for the whole struct
    assign nv_wr = '{valid: busy, index: nv_idx, data: item_value};

endmodule // drpm_bank

`default_nettype wire

// ### logic/drpm_pkg.sv
`default_nettype none
package drpm_pkg;

    // Parameter addresses on the fieldbus parameter channel
    localparam logic [15:0] ADDR_NV_STORE      = 16'h0402;
    localparam logic [15:0] ADDR_USER_DEFAULTS = 16'h0410;
    localparam logic [15:0] ADDR_UV_OFF        = 16'h1008;
    localparam logic [15:0] ADDR_UV_STOP       = 16'h1014;
    localparam logic [15:0] ADDR_FAULT_REACT   = 16'h180e;
    localparam logic [15:0] ADDR_RESTORE       = 16'h0420;
    localparam logic [15:0] ADDR_STATION       = 16'h0422;

    // Field positions and values
    localparam int          CMD_BIT            = 0;
    localparam logic [15:0] RESTORE_NONE       = 16'h0000;
    localparam logic [15:0] RESTORE_FACTORY    = 16'h0001;
    localparam logic [15:0] CMD_BUSY_VALUE     = 16'h0001;
    localparam logic [15:0] STATION_MIN        = 16'h0001;
    localparam logic [15:0] STATION_MAX        = 16'h007e;
    localparam logic [15:0] REACT_MODE_ERROR   = 16'h0000;
    localparam logic [15:0] REACT_CLASS1       = 16'h0001;

    // Factory and reset values
    localparam logic [15:0] FACTORY_STATION    = 16'h007e;
    localparam logic [15:0] FACTORY_REACT      = 16'h0000;

    // Nonvolatile item indices
    localparam logic [3:0]  NV_IDX_STATION     = 4'h0;
    localparam logic [3:0]  NV_IDX_REACT       = 4'h1;
    localparam logic [3:0]  NV_IDX_LAST        = 4'h1;

    // Parameter channel request and answer
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } drpm_req_t;

    typedef struct packed {
        logic        valid;
        logic        err;
        logic [15:0] rdata;
    } drpm_rsp_t;

    // Word offered to the nonvolatile store
    typedef struct packed {
        logic        valid;
        logic [3:0]  index;
        logic [15:0] data;
    } drpm_nv_t;

    // Sequencer of NV writes
    typedef enum logic [1:0] {
        NV_IDLE  = 2'b01,
        NV_WRITE = 2'b10
    } drpm_nv_state_t;

endpackage

`default_nettype wire

// ### testbench/drpm_bank_sva.sv
`timescale 1ns/10ps
`default_nettype none
module drpm_bank_sva
    import drpm_pkg::*;
(
    input wire logic        clk,            // Clock
    input wire logic        nrst,           // Reset, active low
    input wire drpm_req_t   req,            // Request
    input wire drpm_rsp_t   rsp,            // Answer
    input wire logic [15:0] dc_bus_voltage, // Bus voltage
    input wire logic [15:0] uv_off_level,   // Off threshold
    input wire logic [15:0] uv_stop_level,  // Stop threshold
    input wire logic [15:0] boot_station,   // Boot station
    input wire logic [15:0] boot_react,     // Boot reaction
    input wire drpm_nv_t    nv_wr,          // NV word
    input wire logic        nv_wr_ready,    // NV accept
    input wire logic        drive_disable,  // Drive off
    input wire logic        quick_stop,     // Quick Stop
    input wire logic [15:0] active_station, // Station in use
    input wire logic        react_class1    // Class 1 reaction
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // A write aimed at one address
    sequence wr_at(a);
        req.valid && req.write && req.addr == a;
    endsequence
    off_low_a: assert property (dc_bus_voltage <= uv_off_level |=> drive_disable)
        else $error("drive left on at low voltage");
    stop_high_a: assert property (dc_bus_voltage > uv_stop_level |=> !quick_stop)
        else $error("quick stop above threshold");
    uv_read_a: assert property (req.valid && !req.write && req.addr == ADDR_UV_OFF
        |=> rsp.rdata == $past(uv_off_level)) else $error("threshold read wrong");
    ro_refuse_a: assert property (wr_at(ADDR_UV_STOP) |=> rsp.err)
        else $error("threshold write not refused");
    station_range_a: assert property (wr_at(ADDR_STATION) ##0
        (req.wdata < STATION_MIN || req.wdata > STATION_MAX) |=> rsp.valid && rsp.err)
        else $error("bad station accepted");
    store_start_a: assert property (wr_at(ADDR_NV_STORE) ##0
        (req.wdata[CMD_BIT] && !nv_wr.valid) |=> nv_wr.valid && nv_wr.index == NV_IDX_STATION)
        else $error("store did not start");
    nv_hold_a: assert property (nv_wr.valid && !nv_wr_ready
        |=> nv_wr.valid && $stable(nv_wr.index)) else $error("NV word dropped");
    last_word_a: assert property (nv_wr.valid && nv_wr_ready && nv_wr.index == NV_IDX_LAST
        |=> !nv_wr.valid) else $error("NV busy after last word");
    user_no_nv_a: assert property (wr_at(ADDR_USER_DEFAULTS) ##0 !nv_wr.valid
        |=> !nv_wr.valid [*2]) else $error("user reset touched NV");
    station_fixed_a: assert property ($past(nrst, 2) |-> $stable(active_station))
        else $error("station changed before power-up");
endmodule // drpm_bank_sva
bind drpm_bank drpm_bank_sva u_drpm_bank_sva (.clk(clk), .nrst(nrst), .req(req), .rsp(rsp),
    .dc_bus_voltage(dc_bus_voltage), .uv_off_level(uv_off_level),
    .uv_stop_level(uv_stop_level), .boot_station(boot_station), .boot_react(boot_react),
    .nv_wr(nv_wr), .nv_wr_ready(nv_wr_ready), .drive_disable(drive_disable),
    .quick_stop(quick_stop), .active_station(active_station), .react_class1(react_class1));
`default_nettype wire

// ### testbench/drpm_nv_model.sv
`timescale 1ns/10ps
`default_nettype none
module drpm_nv_model
    import drpm_pkg::*;
(
    input  wire logic        clk,   // Clock
    input  wire logic        nrst,  // Reset, active low
    input  wire drpm_nv_t    nv_wr, // Word offered
    input  wire logic [3:0]  stall, // Wait cycles per word
    output logic             ready, // Word taken
    output logic [1:0][15:0] mem    // Stored items
);
    logic [3:0] wait_cnt;
    // Slow memory: a word is taken only once the wait has run out
    assign ready = nv_wr.valid && (wait_cnt == stall);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_cnt <= 4'h0;
        end else if (ready || !nv_wr.valid) begin
            wait_cnt <= 4'h0;
        end else begin
            wait_cnt <= wait_cnt + 4'h1;
        end
    end
    // Contents survive reset, as real storage does
    always_ff @(posedge clk) begin
        if (ready) begin
            mem[nv_wr.index[0]] <= nv_wr.data;
        end
    end
endmodule // drpm_nv_model
`default_nettype wire

// ### testbench/drpm_bank_bench.sv
`timescale 1ns/10ps
`default_nettype none
module drpm_bank_bench;
    import drpm_pkg::*;
    logic             clk, nrst, rdy, drv_off, qstop, cls1;
    drpm_req_t        req;
    drpm_rsp_t        rsp;
    drpm_nv_t         nv_wr;
    logic [15:0]      volt, uv_off, uv_stop, boot_st, boot_re, act_st;
    logic [3:0]       stall;
    logic [1:0][15:0] mem;
    int               err_count, tests_run;
    drpm_bank u_drpm_bank (.clk(clk), .nrst(nrst), .req(req), .rsp(rsp), .dc_bus_voltage(volt),
        .uv_off_level(uv_off), .uv_stop_level(uv_stop), .boot_station(boot_st),
        .boot_react(boot_re), .nv_wr(nv_wr), .nv_wr_ready(rdy), .drive_disable(drv_off),
        .quick_stop(qstop), .active_station(act_st), .react_class1(cls1));
    drpm_nv_model u_drpm_nv_model (.clk(clk), .nrst(nrst), .nv_wr(nv_wr), .stall(stall),
        .ready(rdy), .mem(mem));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One request, answer read half a cycle after it is taken; one idle cycle follows
    task automatic acc(input logic w, input logic [15:0] a, d, output logic [15:0] v,
                       output logic er);
        req = '{1'b1, w, a, d};
        @(negedge clk);
        v = rsp.rdata;
        er = rsp.err;
        check(16'(rsp.valid), 16'h0001);
        req = '0;
        @(negedge clk);
    endtask
    task automatic rd(input logic [15:0] a, e);
        logic [15:0] v;
        logic        er;
        acc(1'b0, a, 16'h0000, v, er);
        check(v, e);
    endtask
    task automatic wr(input logic [15:0] a, d, input logic e);
        logic [15:0] v;
        logic        er;
        acc(1'b1, a, d, v, er);
        check(16'(er), 16'(e));
    endtask
    // Bounded poll until the command reads zero
    task automatic poll(input logic [15:0] a);
        logic [15:0] v;
        logic        er;
        v = 16'h0001;
        for (int n = 0; n < 40 && v !== 16'h0000; n++) begin
            acc(1'b0, a, 16'h0000, v, er);
        end
        check(v, 16'h0000);
    endtask
    task automatic t_boot(input logic [15:0] bs, br, es, input logic ec);
        boot_st = bs;
        boot_re = br;
        nrst = 1'b0;
        repeat (4) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        check(act_st, es);
        check(16'(cls1), 16'(ec));
        $display("boot test done");
    endtask
    task automatic t_thresh();
        logic [15:0] tab [5] = '{16'h0063, 16'h0064, 16'h0065, 16'h0078, 16'h0079};
        foreach (tab[i]) begin
            volt = tab[i];
            repeat (2) @(negedge clk);
            check(16'(drv_off), 16'(tab[i] <= 16'h0064));
            check(16'(qstop), 16'(tab[i] <= 16'h0078));
        end
        rd(ADDR_UV_OFF, 16'h0064);
        rd(ADDR_UV_STOP, 16'h0078);
        wr(ADDR_UV_STOP, 16'h0005, 1'b1);
        rd(16'h0abc, 16'h0000);
        $display("threshold test done");
    endtask
    task automatic t_store();
        wr(ADDR_STATION, 16'h0000, 1'b1);
        wr(ADDR_STATION, 16'h007f, 1'b1);
        wr(ADDR_STATION, 16'h0001, 1'b0);
        wr(ADDR_STATION, 16'h0005, 1'b0);
        wr(ADDR_FAULT_REACT, 16'h0002, 1'b1);
        wr(ADDR_FAULT_REACT, REACT_MODE_ERROR, 1'b0);
        check(16'(cls1), 16'h0000);
        wr(ADDR_FAULT_REACT, REACT_CLASS1, 1'b0);
        check(16'(cls1), 16'h0001);
        wr(ADDR_NV_STORE, 16'h0000, 1'b0);
        check(16'(nv_wr.valid), 16'h0000);
        stall = 4'h3;
        wr(ADDR_NV_STORE, 16'h0001, 1'b0);
        rd(ADDR_NV_STORE, CMD_BUSY_VALUE);
        wr(ADDR_NV_STORE, 16'h0001, 1'b1);
        poll(ADDR_NV_STORE);
        check(mem[0], 16'h0005);
        check(mem[1], REACT_CLASS1);
        check(act_st, 16'h0021);
        $display("store test done");
    endtask
    task automatic t_user();
        wr(ADDR_USER_DEFAULTS, 16'h0001, 1'b0);
        rd(ADDR_FAULT_REACT, FACTORY_REACT);
        check(16'(cls1), 16'h0000);
        rd(ADDR_STATION, 16'h0005);
        check(mem[1], REACT_CLASS1);
        $display("user reset test done");
    endtask
    task automatic t_restore();
        stall = 4'h0;
        wr(ADDR_RESTORE, 16'h0002, 1'b1);
        wr(ADDR_RESTORE, RESTORE_NONE, 1'b0);
        check(16'(nv_wr.valid), 16'h0000);
        wr(ADDR_RESTORE, RESTORE_FACTORY, 1'b0);
        poll(ADDR_RESTORE);
        check(mem[0], FACTORY_STATION);
        check(mem[1], FACTORY_REACT);
        rd(ADDR_STATION, 16'h0005);
        check(act_st, 16'h0021);
        $display("restore test done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Run needs under a hundred cycles; cut off at 2000
    initial begin
        #200000;
        err_count++;
        report_and_stop();
    end
    initial begin
        {nrst, req, volt, boot_st, boot_re, stall, err_count, tests_run} = '0;
        uv_off = 16'h0064;
        uv_stop = 16'h0078;
        @(negedge clk);
        t_boot(16'h0021, 16'h0001, 16'h0021, 1'b1);
        t_thresh();
        t_store();
        t_user();
        t_restore();
        t_boot(16'h0000, 16'h0002, STATION_MAX, 1'b0);
        report_and_stop();
    end
endmodule // drpm_bank_bench
`default_nettype wire
